// ==== bench/fso_host_model.sv ====
// Purpose: Host processor model on the controller register bus
// Assumes: One-cycle strobes launched 1 ns after the rising edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module fso_host_model (
  input wire logic clk_sys,
  output logic busCs,
  output logic busRd,
  output logic busWr,
  output logic [2:0] busAddr,
  output logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  input wire logic [7:0] busRdataOe
);
  initial begin
    busCs = 1'b0;
    busRd = 1'b0;
    busWr = 1'b0;
    busAddr = 3'h0;
    busWdata = 8'h00;
  end

  // Read data stands one cycle only, so it is taken right after the edge
  task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w,
                     output logic [7:0] q, output logic [7:0] oe);
    @(posedge clk_sys);
    #1;
    busCs = 1'b1;
    busRd = !w;
    busWr = w;
    busAddr = a;
    busWdata = d;
    @(posedge clk_sys);
    #1;
    busCs = 1'b0;
    busRd = 1'b0;
    busWr = 1'b0;
    busAddr = ~a;
    busWdata = ~d;
    q = busRdata;
    oe = busRdataOe;
  endtask
endmodule // fso_host_model

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the floppy status and output registers
// Assumes: Inputs change 1 ns after the rising edge of clk_sys
// Notes: Seeded random sweep plus directed latch, reset and tape cases
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb
  import fso_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  fso_mode_t regMode = FSO_MODE_BASE;
  fso_mode_t m;
  logic fourDriveMode = 1'b1;
  logic tapeHighFloat = 1'b0;
  logic busCs, busRd, busWr;
  logic [2:0] busAddr;
  logic [7:0] busWdata, busRdata, busRdataOe, q, oe;
  logic secDrvN = 1'b1, trkZeroN = 1'b1, idxN = 1'b1, wpN = 1'b1, rdN = 1'b1;
  logic stepOut = 1'b0, dirOut = 1'b0, hsel = 1'b0, wrGate = 1'b0, wdata = 1'b0;
  logic dmaReq = 1'b0, irq = 1'b0, tW = 1'b0, tR = 1'b0;
  logic [3:0] motorEnable, driveSelect;
  logic irqPin, irqOe, dmaOe, dackEn, ctrlReset, tapeSupport;
  logic [1:0] tapeSel;
  logic [7:0] drvOut = 8'h00;
  logic [7:0] tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
  int fails = 0;
  int cmp_count = 0;
  int i;

  fso_status_output_regs dut (.clk_sys(clk_sys), .rst(rst), .regMode(regMode),
    .fourDriveMode(fourDriveMode), .tapeHighFloat(tapeHighFloat), .busCs(busCs),
    .busRd(busRd), .busWr(busWr), .busAddr(busAddr), .busWdata(busWdata),
    .busRdata(busRdata), .busRdataOe(busRdataOe), .secondDrivePresentN(secDrvN),
    .trackZeroInputN(trkZeroN), .indexInputN(idxN), .writeProtectN(wpN), .readDataN(rdN),
    .stepOut(stepOut), .dirOut(dirOut), .headSelectOut(hsel), .writeGateOut(wrGate),
    .writeDataOut(wdata), .dmaReqIn(dmaReq), .irqIn(irq), .motorEnable(motorEnable),
    .driveSelect(driveSelect), .floppyInterruptPin(irqPin), .floppyInterruptOe(irqOe),
    .dmaReqOe(dmaOe), .dackTcEnable(dackEn), .ctrlReset(ctrlReset), .tapeSel(tapeSel),
    .tapeSupport(tapeSupport));
  fso_host_model host (.clk_sys(clk_sys), .busCs(busCs), .busRd(busRd), .busWr(busWr),
    .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .busRdataOe(busRdataOe));

  always #4 clk_sys = ~clk_sys;

  function automatic logic [7:0] expA(input fso_mode_t md);
    logic d2;
    d2 = fourDriveMode ? secDrvN : 1'b1;
    if (md == FSO_MODE_EXT) return {irq, d2, 1'b0, trkZeroN, hsel, idxN, wpN, dirOut};
    return {irq & drvOut[3], dmaReq, 1'b0, ~trkZeroN, ~hsel, ~idxN, ~wpN, ~dirOut};
  endfunction

  function automatic logic [7:0] expB(input fso_mode_t md);
    logic [3:0] s;
    s = 4'h1 << drvOut[1:0];
    if (md == FSO_MODE_EXT) return {2'b11, drvOut[0], tW, tR, wrGate, drvOut[5:4]};
    return {fourDriveMode ? secDrvN : 1'b1, ~s[1], ~s[0], 3'b000, ~s[3], ~s[2]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.acc(a, d, 1'b1, q, oe);
    if (a == FSO_OFS_DRIVE_OUT) drvOut = (regMode == FSO_MODE_EXT) ? (d & 8'hf7) : d;
  endtask

  task automatic rd(input logic [2:0] a);
    host.acc(a, 8'h00, 1'b0, q, oe);
  endtask

  task automatic chkOut;
    logic en;
    en = (regMode == FSO_MODE_EXT) | drvOut[3];
    `CHK(motorEnable, drvOut[7:4] & (fourDriveMode ? 4'hf : 4'h3))
    `CHK(driveSelect, 4'h1 << drvOut[1:0])
    `CHK({irqOe, dmaOe, dackEn}, {3{en}})
    `CHK(irqPin, irq & en)
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hce19));
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    cyc(1);
    `CHK({motorEnable, driveSelect, ctrlReset, tapeSel}, 11'b00000001100)
    foreach (tbl[k]) begin
      wr(FSO_OFS_DRIVE_OUT, tbl[k]);
      cyc(2);
      chkOut();
    end
    cyc(20);
    `CHK(ctrlReset, 1'b0)
    wr(FSO_OFS_TAPE, 8'h03);
    // Two writes toggle the reset bit; the device stretches the hold
    wr(FSO_OFS_DRIVE_OUT, 8'h8b);
    wr(FSO_OFS_DRIVE_OUT, 8'h8f);
    cyc(1);
    `CHK(ctrlReset, 1'b1)
    cyc(10);
    `CHK(ctrlReset, 1'b1)
    cyc(8);
    `CHK(ctrlReset, 1'b0)
    chkOut();
    `CHK({tapeSel, tapeSupport}, 3'b111)
    rd(FSO_OFS_TAPE);
    `CHK({q, oe}, 16'h23ff)
    tapeHighFloat = 1'b1;
    rd(FSO_OFS_TAPE);
    `CHK(oe, FSO_BUS_OE_TAPE_LOW)
    tapeHighFloat = 1'b0;
    wr(FSO_OFS_TAPE, 8'h00);
    wr(FSO_OFS_DRIVE_OUT, 8'h0c);
    rd(3'h6);
    `CHK(oe, 8'h00)
    `CHK(tapeSupport, 1'b0)
    regMode = FSO_MODE_INV;
    rd(FSO_OFS_DIG_IN);
    {stepOut, wrGate, wdata, rdN} = 4'b1110;
    cyc(2);
    {stepOut, wdata, rdN} = 3'b001;
    {tW, tR} = ~{tW, tR};
    cyc(5);
    rd(FSO_OFS_STATUS_A);
    `CHK(q[5], 1'b1)
    rd(FSO_OFS_STATUS_B);
    `CHK(q[4:2], 3'b111)
    rd(FSO_OFS_DIG_IN);
    rd(FSO_OFS_STATUS_A);
    `CHK(q[5], 1'b0)
    rd(FSO_OFS_STATUS_B);
    `CHK(q, expB(regMode))
    regMode = FSO_MODE_EXT;
    {wrGate, wdata, stepOut} = 3'b011;
    cyc(2);
    wdata = 1'b0;
    tW = ~tW;
    cyc(5);
    rd(FSO_OFS_STATUS_A);
    `CHK(q, expA(regMode) | 8'h20)
    stepOut = 1'b0;
    rd(FSO_OFS_STATUS_B);
    `CHK(q, expB(regMode))
    for (i = 0; i < 40; i++) begin
      m = fso_mode_t'(2'($urandom_range(2)));
      regMode = m;
      {fourDriveMode, secDrvN, trkZeroN, idxN, wpN, dirOut, hsel, dmaReq, irq} = 9'($urandom);
      wr(FSO_OFS_DRIVE_OUT, 8'($urandom) | 8'h04);
      rd(FSO_OFS_DIG_IN);
      cyc(4);
      chkOut();
      rd(FSO_OFS_STATUS_A);
      `CHK(oe, (m == FSO_MODE_BASE) ? 8'h00 : 8'hff)
      `CHK(q & oe, expA(m) & oe)
      rd(FSO_OFS_STATUS_B);
      `CHK(oe, (m == FSO_MODE_BASE) ? 8'h00 : 8'hff)
      `CHK(q & oe, expB(m) & oe)
    end
    regMode = FSO_MODE_EXT;
    rst = 1'b1;
    cyc(2);
    `CHK({motorEnable, driveSelect, irqPin}, 9'b000000010)
    `CHK({irqOe, dmaOe, dackEn}, 3'b111)
    rst = 1'b0;
    {drvOut, tW, tR} = 10'h000;
    regMode = FSO_MODE_EXT;
    cyc(2);
    rd(FSO_OFS_STATUS_B);
    `CHK(q, expB(regMode))
    wrap_up();
  end
endmodule // tb

// ==== src/fso_pkg.sv ====
// Purpose: Shared constants for the floppy status and output register bank
// Assumes: 8-bit host data, 3-bit I/O offset within the controller range
// Notes: Timing counts are derived from the 125 MHz system clock
package fso_pkg;

  // Register offsets within the controller range
  localparam logic [2:0] FSO_OFS_STATUS_A = 3'h0;
  localparam logic [2:0] FSO_OFS_STATUS_B = 3'h1;
  localparam logic [2:0] FSO_OFS_DRIVE_OUT = 3'h2;
  localparam logic [2:0] FSO_OFS_TAPE = 3'h3;
  localparam logic [2:0] FSO_OFS_DIG_IN = 3'h7;

  // Reset values
  localparam logic [7:0] FSO_DRIVE_OUT_RST = 8'h00;
  localparam logic [1:0] FSO_TAPE_RST = 2'h0;

  // Drive output control field positions
  localparam int FSO_DOC_MOTOR_LSB = 4;
  localparam int FSO_DOC_DMA_GATE = 3;
  localparam int FSO_DOC_RESET = 2;
  localparam int FSO_DOC_SEL_LSB = 0;

  // Tape register: valid-data bit reads one, no media sense here
  localparam int FSO_TAPE_VALID_BIT = 5;
  localparam logic [7:0] FSO_BUS_OE_ALL = 8'hff;
  localparam logic [7:0] FSO_BUS_OE_TAPE_LOW = 8'h03;

  // Least software reset hold time
  localparam int FSO_CLK_PERIOD_PS = 8000;
  localparam int FSO_SWRST_MIN_NS = 100;
  localparam int FSO_SWRST_CYCLES = (FSO_SWRST_MIN_NS * 1000 + FSO_CLK_PERIOD_PS - 1)
                                    / FSO_CLK_PERIOD_PS;

  // Register mode
  typedef enum logic [1:0] {
    FSO_MODE_BASE = 2'b00,
    FSO_MODE_EXT = 2'b01,
    FSO_MODE_INV = 2'b10
  } fso_mode_t;

endpackage

// ==== src/fso_status_output_regs.sv ====
// Purpose: Diagnostic status, drive output control and tape assignment registers
// Assumes: Host strobes are one-cycle pulses synchronous to clk_sys
// Notes: Read data is registered and stands for one cycle after the strobe
// Operation
// RULE1: Status registers answer only in extended or inverted mode, else bus floats.
// RULE2: Status A bit 7 follows interrupt pin level in both diagnostic modes.
// RULE3: Extended status A shows drive2, step, track0, head, index, protect, direction.
// RULE4: Inverted status A shows DMA request, inverted disk inputs and head outputs.
// RULE5: Inverted status A bit 5 latches step; cleared by input read or resets.
// RULE6: Extended status B bits 7 and 6 read as one.
// RULE7: Extended status B bit 5 mirrors drive select bit 0; hardware reset only.
// RULE8: Extended status B bits 4,3 toggle on inactive write/read data edges.
// RULE9: Extended status B shows write gate and motor enables 1 and 0.
// RULE10: Inverted status B shows drive2 and four drive selects, active low.
// RULE11: Inverted status B latches write data, read data, write gate; input read clears.
// RULE12: Drive output register clears on hardware reset only, writable any time.
// RULE13: Drive output bits 7 to 4 drive motor enables 3 to 0.
// RULE14: Base and inverted modes: bit 3 gates DMA and interrupt pins.
// RULE15: Extended mode: bit 3 reserved, DMA and interrupt pins always enabled.
// RULE16: Bit 2 low holds controller reset; hold lasts at least 100 ns.
// RULE17: Software reset spares drive output bits, resets command settings only.
// RULE18: Drive select bits decode to exactly one active drive select.
// RULE19: Motors 3,2 and extra drive inputs only in four-drive mode.
// RULE20: Values 1Ch, 2Dh, 4Eh, 8Fh enable motor and select together.
// RULE21: Tape register survives software reset; assigned drive access invokes tape support.
// RULE22: Function control bit 0 floats tape register bits 7 to 2 on reads.
// RULE23: Tape select codes drives 1 to 3; drive 0 never a tape drive.
// RULE24: Disk interface inputs are synchronised before use.
`timescale 1ns/100ps
module fso_status_output_regs
  import fso_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire fso_mode_t regMode,
  input wire logic fourDriveMode,
  input wire logic tapeHighFloat,
  input wire logic busCs,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [2:0] busAddr,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  output logic [7:0] busRdataOe,
  input wire logic secondDrivePresentN,
  input wire logic trackZeroInputN,
  input wire logic indexInputN,
  input wire logic writeProtectN,
  input wire logic readDataN,
  input wire logic stepOut,
  input wire logic dirOut,
  input wire logic headSelectOut,
  input wire logic writeGateOut,
  input wire logic writeDataOut,
  input wire logic dmaReqIn,
  input wire logic irqIn,
  output logic [3:0] motorEnable,
  output logic [3:0] driveSelect,
  output logic floppyInterruptPin,
  output logic floppyInterruptOe,
  output logic dmaReqOe,
  output logic dackTcEnable,
  output logic ctrlReset,
  output logic [1:0] tapeSel,
  output logic tapeSupport
);

  logic [7:0] driveOut_q;
  logic [1:0] tape_q;
  logic [4:0] syncA_q;
  logic [4:0] syncB_q;
  logic rdPrev_q;
  logic wdPrev_q;
  logic stepPrev_q;
  logic wgPrev_q;
  logic wdToggle_q;
  logic rdToggle_q;
  logic stepLatch_q;
  logic wdLatch_q;
  logic rdLatch_q;
  logic wgLatch_q;
  logic [7:0] swRstCnt_q;
  logic irqGate;
  logic swReset;
  logic readStrobe;
  logic writeStrobe;
  logic digInRead;
  logic rdInactEdge;
  logic wdInactEdge;
  logic diagMode;
  logic secondDrvN;
  logic trackZeroN;
  logic indexN;
  logic wpN;
  logic rdataN;
  logic [7:0] statusA;
  logic [7:0] statusB;
  logic [7:0] rdData_d;
  logic [7:0] rdOe_d;

  assign readStrobe = busCs && busRd;
  assign writeStrobe = busCs && busWr;
  assign digInRead = readStrobe && (busAddr == FSO_OFS_DIG_IN);
  assign diagMode = (regMode == FSO_MODE_EXT) || (regMode == FSO_MODE_INV);
  assign swReset = !driveOut_q[FSO_DOC_RESET];
  assign irqGate = (regMode == FSO_MODE_EXT) || driveOut_q[FSO_DOC_DMA_GATE]; // RULE14 RULE15
  assign {secondDrvN, trackZeroN, indexN, wpN, rdataN} = syncB_q;

  // Two-flop synchroniser; only the second stage is looked at
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_q <= 5'h1f;
      syncB_q <= 5'h1f;
    end else begin
      syncA_q <= {secondDrivePresentN, trackZeroInputN, indexInputN, writeProtectN, readDataN};
      syncB_q <= syncA_q; // RULE24
    end
  end

  // Edge history for pulse-type disk signals
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdPrev_q <= 1'b1;
      wdPrev_q <= 1'b0;
      stepPrev_q <= 1'b0;
      wgPrev_q <= 1'b0;
    end else begin
      rdPrev_q <= rdataN;
      wdPrev_q <= writeDataOut;
      stepPrev_q <= stepOut;
      wgPrev_q <= writeGateOut;
    end
  end

  // Read data pin is active low, so its inactive edge is a rise
  assign rdInactEdge = rdataN && !rdPrev_q;
  assign wdInactEdge = !writeDataOut && wdPrev_q;

  // Drive output control; a software reset leaves it alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      driveOut_q <= FSO_DRIVE_OUT_RST; // RULE12
    end else if (writeStrobe && busAddr == FSO_OFS_DRIVE_OUT) begin
      driveOut_q <= busWdata; // RULE12 RULE17 RULE20
      if (regMode == FSO_MODE_EXT) begin
        driveOut_q[FSO_DOC_DMA_GATE] <= 1'b0; // RULE15
      end
    end
  end

  // Tape assignment survives software reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tape_q <= FSO_TAPE_RST;
    end else if (writeStrobe && busAddr == FSO_OFS_TAPE) begin
      tape_q <= busWdata[1:0]; // RULE21 RULE23
    end
  end

  // Toggle bits are cleared by hardware reset only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdToggle_q <= 1'b0;
      rdToggle_q <= 1'b0;
    end else begin
      if (wdInactEdge) begin
        wdToggle_q <= !wdToggle_q; // RULE8
      end
      if (rdInactEdge) begin
        rdToggle_q <= !rdToggle_q; // RULE8
      end
    end
  end

  // Sticky latches: a new edge in the clearing cycle is kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stepLatch_q <= 1'b0;
      wdLatch_q <= 1'b0;
      rdLatch_q <= 1'b0;
      wgLatch_q <= 1'b0;
    end else begin
      if (stepOut && !stepPrev_q) begin
        stepLatch_q <= 1'b1; // RULE5
      end else if (digInRead || swReset) begin
        stepLatch_q <= 1'b0; // RULE5
      end
      if (wdInactEdge) begin
        wdLatch_q <= 1'b1; // RULE11
      end else if (digInRead) begin
        wdLatch_q <= 1'b0; // RULE11
      end
      if (rdInactEdge) begin
        rdLatch_q <= 1'b1; // RULE11
      end else if (digInRead) begin
        rdLatch_q <= 1'b0; // RULE11
      end
      if (writeGateOut && !wgPrev_q) begin
        wgLatch_q <= 1'b1; // RULE11
      end else if (digInRead) begin
        wgLatch_q <= 1'b0; // RULE11
      end
    end
  end

  // Stretch the controller reset so a quick toggle still meets the hold time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      swRstCnt_q <= 8'(FSO_SWRST_CYCLES);
      ctrlReset <= 1'b1;
    end else begin
      if (swReset) begin
        swRstCnt_q <= 8'(FSO_SWRST_CYCLES);
      end else if (swRstCnt_q != 8'h00) begin
        swRstCnt_q <= swRstCnt_q - 8'h01;
      end
      ctrlReset <= swReset || (swRstCnt_q > 8'h01); // RULE16
    end
  end

  // Disk and pin outputs, all registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      motorEnable <= 4'h0;
      driveSelect <= 4'h1;
      floppyInterruptPin <= 1'b0;
      tapeSel <= 2'h0;
      tapeSupport <= 1'b0;
    end else begin
      motorEnable <= driveOut_q[FSO_DOC_MOTOR_LSB +: 4] &
                     {{2{fourDriveMode}}, 2'b11}; // RULE13 RULE19
      driveSelect <= 4'h1 << driveOut_q[FSO_DOC_SEL_LSB +: 2]; // RULE18
      floppyInterruptPin <= irqIn && irqGate;
      tapeSel <= tape_q;
      tapeSupport <= (tape_q != 2'h0) &&
                     (driveOut_q[FSO_DOC_SEL_LSB +: 2] == tape_q); // RULE21 RULE23
    end
  end

  // No reset here: extended mode must keep the pins enabled through hardware reset
  always_ff @(posedge clk_sys) begin
    floppyInterruptOe <= irqGate; // RULE14 RULE15
    dmaReqOe <= irqGate; // RULE14 RULE15
    dackTcEnable <= irqGate; // RULE14 RULE15
  end

  // Status register views
  always_comb begin
    if (regMode == FSO_MODE_INV) begin
      statusA = {floppyInterruptPin, dmaReqIn, stepLatch_q, !trackZeroN,
                 !headSelectOut, !indexN, !wpN, !dirOut}; // RULE2 RULE4 RULE5
      statusB = {secondDrvN || !fourDriveMode, !driveSelect[1], !driveSelect[0], wdLatch_q,
                 rdLatch_q, wgLatch_q, !driveSelect[3], !driveSelect[2]}; // RULE10 RULE11 RULE19
    end else begin
      statusA = {floppyInterruptPin, secondDrvN || !fourDriveMode, stepOut, trackZeroN,
                 headSelectOut, indexN, wpN, dirOut}; // RULE2 RULE3
      statusB = {2'b11, driveOut_q[FSO_DOC_SEL_LSB], wdToggle_q, rdToggle_q,
                 writeGateOut, motorEnable[1], motorEnable[0]}; // RULE6 RULE7 RULE8 RULE9
    end
  end

  // Host read mux; unmapped offsets leave the bus floating
  always_comb begin
    rdData_d = 8'h00;
    rdOe_d = 8'h00;
    case (busAddr)
      FSO_OFS_STATUS_A: begin
        rdData_d = statusA;
        rdOe_d = diagMode ? FSO_BUS_OE_ALL : 8'h00; // RULE1
      end
      FSO_OFS_STATUS_B: begin
        rdData_d = statusB;
        rdOe_d = diagMode ? FSO_BUS_OE_ALL : 8'h00; // RULE1
      end
      FSO_OFS_DRIVE_OUT: begin
        rdData_d = driveOut_q;
        rdOe_d = FSO_BUS_OE_ALL;
      end
      FSO_OFS_TAPE: begin
        rdData_d = {2'b00, 1'b1, 3'b000, tape_q};
        rdData_d[FSO_TAPE_VALID_BIT] = 1'b1;
        rdOe_d = tapeHighFloat ? FSO_BUS_OE_TAPE_LOW : FSO_BUS_OE_ALL; // RULE22
      end
      default: begin
        rdData_d = 8'h00;
        rdOe_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busRdata <= 8'h00;
      busRdataOe <= 8'h00;
    end else if (readStrobe) begin
      busRdata <= rdData_d;
      busRdataOe <= rdOe_d;
    end else begin
      busRdata <= 8'h00;
      busRdataOe <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_base_status_float: assert property ( // RULE1
    readStrobe && busAddr == FSO_OFS_STATUS_A && regMode == FSO_MODE_BASE
    |=> busRdataOe == 8'h00) else $error("status A driven in base mode");

  a_irq_bit_read: assert property ( // RULE2
    readStrobe && busAddr == FSO_OFS_STATUS_A && diagMode && $stable(regMode)
    |=> busRdata[7] == $past(floppyInterruptPin)) else $error("status A bit 7 wrong");

  a_step_latch_set: assert property ( // RULE5
    $rose(stepOut) && !swReset |=> stepLatch_q) else $error("step latch missed");

  a_step_latch_clr: assert property ( // RULE5
    digInRead && !(stepOut && !stepPrev_q) |=> !stepLatch_q) else $error("step latch kept");

  a_wd_toggle: assert property ( // RULE8
    $fell(writeDataOut) |=> wdToggle_q != $past(wdToggle_q)) else $error("write data toggle");

  a_drive_out_write: assert property ( // RULE12
    writeStrobe && busAddr == FSO_OFS_DRIVE_OUT && regMode != FSO_MODE_EXT
    |=> driveOut_q == $past(busWdata)) else $error("drive output write lost");

  a_motor_follow: assert property ( // RULE13
    fourDriveMode && $stable(fourDriveMode) ##1 $stable(fourDriveMode)
    |-> motorEnable == $past(driveOut_q[7:4])) else $error("motor enables mismatch");

  a_irq_gate_ext: assert property ( // RULE15
    regMode == FSO_MODE_EXT ##1 regMode == FSO_MODE_EXT |-> dmaReqOe && dackTcEnable)
    else $error("pins disabled in extended mode");

  a_swrst_hold: assert property ( // RULE16
    $rose(driveOut_q[FSO_DOC_RESET]) |-> ctrlReset [*8]) else $error("reset released early");

  a_one_select: assert property ( // RULE18
    $onehot(driveSelect)) else $error("drive select not one-hot");

  a_tape_no_drv0: assert property ( // RULE23
    tapeSel == 2'h0 |-> !tapeSupport) else $error("drive 0 tape support");

  c_inv_status_b: cover property (readStrobe && busAddr == FSO_OFS_STATUS_B &&
                                  regMode == FSO_MODE_INV);
  c_swrst_toggle: cover property (swReset ##1 !swReset);
  c_tape_access: cover property (tapeSupport);
  c_latch_clear: cover property (wgLatch_q ##1 digInRead ##1 !wgLatch_q);

endmodule // fso_status_output_regs
